/* common/ssr_pkg.sv */
// Package of offsets, bit positions and reset values for the status block
package ssr_pkg;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int IRQ_W = 3;

  typedef logic [DATA_W-1:0] ssr_byte_t;
  typedef logic [ADDR_W-1:0] ssr_addr_t;
  typedef logic [IRQ_W-1:0] ssr_irq_t;

  // Register offsets
  localparam ssr_addr_t OFF_QUERY = 4'h0;
  localparam ssr_addr_t OFF_POLL = 4'h1;
  localparam ssr_addr_t OFF_CLEAR = 4'h2;
  localparam ssr_addr_t OFF_MASK = 4'h3;
  localparam ssr_addr_t OFF_IRQ_STAT = 4'h4;
  localparam ssr_addr_t OFF_IRQ_CLR = 4'h5;
  localparam ssr_addr_t OFF_IRQ_EN = 4'h6;

  // Status bit positions, weight is two to the position
  localparam int BIT_SUBPROG = 0;
  localparam int BIT_LIMIT = 1;
  localparam int BIT_SRQ_CMD = 2;
  localparam int BIT_POWER_ON = 3;
  localparam int BIT_READY = 4;
  localparam int BIT_ERROR = 5;
  localparam int BIT_SUMMARY = 6;
  localparam int BIT_DATA = 7;

  // Field masks
  localparam ssr_byte_t QUERY_HIDE = 8'h10;
  localparam ssr_byte_t PERSIST_MASK = 8'h30;
  localparam ssr_byte_t SUMMARY_MASK = 8'h40;

  // Reset values
  localparam ssr_byte_t STATUS_RST = 8'h08;
  localparam ssr_byte_t MASK_RST = 8'h00;
  localparam ssr_irq_t IRQ_RST = 3'h0;

  // Interrupt bit positions
  localparam int IRQ_SRQ_RAISED = 0;
  localparam int IRQ_POLL_CLEAR = 1;
  localparam int IRQ_STAT_CLEAR = 2;

endpackage

/* common/ssr_sticky_if.sv */
// Interface between the sticky bit store and its owner
`timescale 1ns/10ps
interface ssr_sticky_if #(parameter int W = 8);
  logic [W-1:0] set;
  logic [W-1:0] clr;
  logic [W-1:0] keep;
  logic [W-1:0] q;
  logic [W-1:0] nxt;
  modport store (input set, input clr, input keep, output q, output nxt);
  modport user (output set, output clr, output keep, input q, input nxt);
endinterface

/* rtl/ssr_sticky.sv */
// Sticky bit store, set wins over clear
`timescale 1ns/10ps
module ssr_sticky #(
  parameter int W = 8,
  parameter logic [W-1:0] RST = '0
)(
  input wire logic clk,
  input wire logic rst_n,
  ssr_sticky_if.store sif
);

  logic [W-1:0] q_ff;

  always_comb
  begin
    sif.nxt = (q_ff & ~(sif.clr & ~sif.keep)) | sif.set;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      q_ff <= RST;
    else
      q_ff <= sif.nxt;
  end

  assign sif.q = q_ff;

endmodule

/* rtl/ssr_regport.sv */
// Register port decode and registered read data
`timescale 1ns/10ps
module ssr_regport
  import ssr_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire ssr_addr_t addr,
  input wire logic wr,
  input wire logic rd,
  input wire ssr_byte_t status_q,
  input wire ssr_byte_t mask_q,
  input wire ssr_irq_t irq_q,
  input wire ssr_irq_t irq_en_q,
  output logic wr_clear,
  output logic wr_mask,
  output logic wr_irq_clr,
  output logic wr_irq_en,
  output logic rd_query,
  output logic rd_poll,
  output ssr_byte_t rdata
);

  ssr_byte_t nxt_rdata;
  ssr_byte_t rdata_ff;

  always_comb
  begin
    wr_clear = wr && (addr == OFF_CLEAR);
    wr_mask = wr && (addr == OFF_MASK);
    wr_irq_clr = wr && (addr == OFF_IRQ_CLR);
    wr_irq_en = wr && (addr == OFF_IRQ_EN);
    rd_query = rd && (addr == OFF_QUERY);
    rd_poll = rd && (addr == OFF_POLL);
  end

  // Read mux, unmapped and write-only offsets read zero
  always_comb
  begin
    nxt_rdata = '0;
    if (rd)
    begin
      case (addr)
        OFF_QUERY: nxt_rdata = status_q & ~QUERY_HIDE;
        OFF_POLL: nxt_rdata = status_q;
        OFF_MASK: nxt_rdata = mask_q;
        OFF_IRQ_STAT: nxt_rdata = {{(DATA_W-IRQ_W){1'b0}}, irq_q};
        OFF_IRQ_EN: nxt_rdata = {{(DATA_W-IRQ_W){1'b0}}, irq_en_q};
        default: nxt_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      rdata_ff <= '0;
    else
      rdata_ff <= nxt_rdata;
  end

  assign rdata = rdata_ff;

endmodule

/* rtl/ssr_top.sv */
// Status byte and service request logic with register port
//
// The implementer's own choices: the address map and the address-and-strobe port.
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////
module ssr_top
  import ssr_pkg::*;
(
  input wire logic MCLK,
  input wire logic RESETN,
  input wire ssr_addr_t ADDR,
  input wire ssr_byte_t WDATA,
  input wire logic WR,
  input wire logic RD,
  output ssr_byte_t RDATA,
  input wire logic EVT_SUBPROG_DONE,
  input wire logic EVT_LIMIT,
  input wire logic EVT_SRQ_CMD,
  input wire logic EVT_POWER_ON,
  input wire logic COND_READY,
  input wire logic COND_ERROR,
  input wire logic EVT_DATA_AVAIL,
  output logic SRQ,
  output logic IRQ
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  ssr_sticky_if #(.W(DATA_W)) st_if ();
  ssr_sticky_if #(.W(IRQ_W)) irq_if ();

  logic wr_clear;
  logic wr_mask;
  logic wr_irq_clr;
  logic wr_irq_en;
  logic rd_query;
  logic rd_poll;
  logic clr_any;
  logic poll_clear;
  logic summary_set;
  logic summary_keep;
  ssr_byte_t ev_vec;
  ssr_byte_t cond_vec;
  ssr_byte_t mask_eff;
  ssr_byte_t mask_ff;
  ssr_byte_t nxt_mask;
  ssr_irq_t irq_en_ff;
  ssr_irq_t nxt_irq_en;
  logic srq_ff;
  logic irq_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Register port

  ssr_regport u_port (
    .clk (MCLK),
    .rst_n (RESETN),
    .addr (ADDR),
    .wr (WR),
    .rd (RD),
    .status_q (st_if.q),
    .mask_q (mask_ff),
    .irq_q (irq_if.q),
    .irq_en_q (irq_en_ff),
    .wr_clear (wr_clear),
    .wr_mask (wr_mask),
    .wr_irq_clr (wr_irq_clr),
    .wr_irq_en (wr_irq_en),
    .rd_query (rd_query),
    .rd_poll (rd_poll),
    .rdata (RDATA)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Service enable mask

  always_comb
  begin
    nxt_mask = mask_ff;
    if (wr_mask)
      nxt_mask = WDATA;
  end

  always_ff @(posedge MCLK)
  begin
    if (!RESETN)
      mask_ff <= MASK_RST;
    else
      mask_ff <= nxt_mask;
  end

  // Bit 6 is the summary itself and never feeds itself
  assign mask_eff = mask_ff & ~SUMMARY_MASK;

  ////////////////////////////////////////////////////////////////////////////
  // Status events and conditions

  always_comb
  begin
    ev_vec = '0;
    ev_vec[BIT_SUBPROG] = EVT_SUBPROG_DONE;
    ev_vec[BIT_LIMIT] = EVT_LIMIT;
    ev_vec[BIT_SRQ_CMD] = EVT_SRQ_CMD;
    ev_vec[BIT_POWER_ON] = EVT_POWER_ON;
    ev_vec[BIT_READY] = COND_READY;
    ev_vec[BIT_ERROR] = COND_ERROR;
    ev_vec[BIT_DATA] = EVT_DATA_AVAIL;
  end

  assign cond_vec = ev_vec & PERSIST_MASK;

  // Clear by command, or by a poll while the request is up
  assign poll_clear = rd_poll && srq_ff;
  assign clr_any = wr_clear || poll_clear;

  // Summary sets from enabled bits, new or standing
  always_comb
  begin
    summary_set = |(ev_vec & mask_eff);
    if (!clr_any)
      summary_set = summary_set || |(st_if.q & mask_eff);
  end

  // Summary survives a clear command while an enabled condition holds
  assign summary_keep = wr_clear && |(cond_vec & mask_eff);

  ////////////////////////////////////////////////////////////////////////////
  // Status register store

  always_comb
  begin
    st_if.set = ev_vec;
    st_if.set[BIT_SUMMARY] = summary_set;
    st_if.clr = {DATA_W{clr_any}};
    st_if.keep = '0;
    if (wr_clear)
    begin
      st_if.keep = cond_vec;
      st_if.keep[BIT_SUMMARY] = summary_keep;
    end
  end

  ssr_sticky #(.W(DATA_W), .RST(STATUS_RST)) u_status (
    .clk (MCLK),
    .rst_n (RESETN),
    .sif (st_if)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Service request line

  always_ff @(posedge MCLK)
  begin
    if (!RESETN)
      srq_ff <= 1'b0;
    else
      srq_ff <= st_if.nxt[BIT_SUMMARY];
  end

  assign SRQ = srq_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts

  always_comb
  begin
    irq_if.set = '0;
    irq_if.set[IRQ_SRQ_RAISED] = st_if.nxt[BIT_SUMMARY] && !srq_ff;
    irq_if.set[IRQ_POLL_CLEAR] = poll_clear;
    irq_if.set[IRQ_STAT_CLEAR] = wr_clear;
    irq_if.clr = '0;
    if (wr_irq_clr)
      irq_if.clr = WDATA[IRQ_W-1:0];
    irq_if.keep = '0;
  end

  ssr_sticky #(.W(IRQ_W), .RST(IRQ_RST)) u_irq (
    .clk (MCLK),
    .rst_n (RESETN),
    .sif (irq_if)
  );

  always_comb
  begin
    nxt_irq_en = irq_en_ff;
    if (wr_irq_en)
      nxt_irq_en = WDATA[IRQ_W-1:0];
  end

  always_ff @(posedge MCLK)
  begin
    if (!RESETN)
      irq_en_ff <= IRQ_RST;
    else
      irq_en_ff <= nxt_irq_en;
  end

  always_ff @(posedge MCLK)
  begin
    if (!RESETN)
      irq_ff <= 1'b0;
    else
      irq_ff <= |(irq_if.nxt & nxt_irq_en);
  end

  assign IRQ = irq_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge MCLK);
  endclocking

  default disable iff (!RESETN);

  // Query answer is the weighted sum, bit 4 hidden
  property p_query_sum;
    rd_query |=> RDATA == ($past(st_if.q) & ~QUERY_HIDE);
  endproperty
  a_query_sum: assert property (p_query_sum)
    else $error("Query answer differs from status");

  property p_query_no_ready;
    (rd_query && COND_READY) ##1 COND_READY |-> !RDATA[BIT_READY];
  endproperty
  a_query_no_ready: assert property (p_query_no_ready)
    else $error("Query answer shows ready bit");

  property p_poll_clears;
    (rd_poll && SRQ) |=>
      (RDATA == $past(st_if.q)) && ((st_if.q & ~$past(st_if.set)) == '0);
  endproperty
  a_poll_clears: assert property (p_poll_clears)
    else $error("Poll with request did not clear status");

  property p_srq_follows;
    !st_if.q[BIT_SUMMARY] |-> !SRQ;
  endproperty
  a_srq_follows: assert property (p_srq_follows)
    else $error("Request line high with summary clear");

  property p_poll_keeps;
    (rd_poll && !SRQ && !wr_clear) |=>
      (RDATA == $past(st_if.q)) && ((st_if.q & $past(st_if.q))
      == $past(st_if.q));
  endproperty
  a_poll_keeps: assert property (p_poll_keeps)
    else $error("Poll without request changed status");

  property p_clear_resets;
    (wr_clear && (ev_vec == '0)) |=> st_if.q == '0;
  endproperty
  a_clear_resets: assert property (p_clear_resets)
    else $error("Clear left a status bit set");

  property p_clear_persist;
    (wr_clear && COND_ERROR && mask_ff[BIT_ERROR]) |=>
      st_if.q[BIT_ERROR] && st_if.q[BIT_SUMMARY] && SRQ;
  endproperty
  a_clear_persist: assert property (p_clear_persist)
    else $error("Persistent bit lost on clear");

  property p_enabled_raises;
    (|(st_if.q & mask_eff) && !clr_any) |=>
      st_if.q[BIT_SUMMARY] && SRQ;
  endproperty
  a_enabled_raises: assert property (p_enabled_raises)
    else $error("Enabled bit did not raise request");

  property p_mask_load;
    wr_mask |=> mask_ff == $past(WDATA);
  endproperty
  a_mask_load: assert property (p_mask_load)
    else $error("Mask not loaded from write data");

  property p_unmasked_quiet;
    (mask_ff == '0 && !st_if.q[BIT_SUMMARY] && !wr_mask) |=> !SRQ;
  endproperty
  a_unmasked_quiet: assert property (p_unmasked_quiet)
    else $error("Unmasked bit raised request");

  property p_query_no_clear;
    (rd_query && !clr_any) |=>
      (st_if.q & $past(st_if.q)) == $past(st_if.q);
  endproperty
  a_query_no_clear: assert property (p_query_no_clear)
    else $error("Query cleared a status bit");

  property p_event_bits;
    (EVT_LIMIT && EVT_DATA_AVAIL) |=>
      st_if.q[BIT_LIMIT] && st_if.q[BIT_DATA];
  endproperty
  a_event_bits: assert property (p_event_bits)
    else $error("Event did not set its status bit");

  property p_reset_quiet;
    $rose(RESETN) |-> (mask_ff == MASK_RST) && !SRQ;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("Mask or request not quiet after reset");

  property p_irq_level;
    ##1 IRQ == |($past(irq_if.nxt) & $past(nxt_irq_en));
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("Interrupt output does not follow status");

endmodule

/* tb/ssr_host.sv */
// Bus controller model that reaches the status block registers
`timescale 1ns/10ps
module ssr_host
  import ssr_pkg::*;
(
  input wire logic clk,
  output ssr_addr_t addr,
  output ssr_byte_t wdata,
  output logic wr,
  output logic rd,
  input wire ssr_byte_t rdata
);
  int gap = 0;

  initial
  begin
    addr = 4'h0;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write, mask value is the sum of chosen weights
  task automatic do_wr(input ssr_addr_t a, input ssr_byte_t v);
    repeat (gap) @(posedge clk);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    addr <= ~a;
    wdata <= ~v;
  endtask

  // Read, serial poll offset shows ready bit
  task automatic do_rd(input ssr_addr_t a, output ssr_byte_t v);
    repeat (gap) @(posedge clk);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    addr <= ~a;
    #1;
    v = rdata;
  endtask
endmodule

/* tb/ssr_top_tb.sv */
// Self-checking testbench for the status block
`timescale 1ns/10ps
module ssr_top_tb
  import ssr_pkg::*;
;
  logic MCLK = 1'b0;
  logic RESETN = 1'b0;
  ssr_byte_t ev = 8'h00;
  ssr_addr_t addr;
  ssr_byte_t wdata;
  ssr_byte_t rdata;
  logic wr;
  logic rd;
  logic srq;
  logic irq;
  int miscompares = 0;
  int checked = 0;
  ssr_byte_t st;
  ssr_byte_t msk;
  ssr_byte_t e;

  always #5 MCLK = ~MCLK;

  ssr_top u_ssr_top (.MCLK(MCLK), .RESETN(RESETN), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .EVT_SUBPROG_DONE(ev[0]), .EVT_LIMIT(ev[1]), .EVT_SRQ_CMD(ev[2]),
    .EVT_POWER_ON(ev[3]), .COND_READY(ev[4]), .COND_ERROR(ev[5]),
    .EVT_DATA_AVAIL(ev[7]), .SRQ(srq), .IRQ(irq));

  ssr_host u_ssr_host (.clk(MCLK), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata));

  ////////////////////////////////////////////////////////////////////////////
  // Expected status after events under a mask
  function automatic ssr_byte_t upd(ssr_byte_t s, ssr_byte_t v, ssr_byte_t m);
    s = s | (v & 8'hbf);
    if (|(s & m & 8'hbf))
      s = s | SUMMARY_MASK;
    return s;
  endfunction

  task final_report;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task chk_byte(input ssr_byte_t got, input ssr_byte_t exp);
    checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %0t: byte %h want %h", $time, got, exp);
    end
  endtask

  task chk_bit(input logic got, input logic exp);
    checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %0t: bit %b want %b", $time, got, exp);
    end
  endtask

  task rdreg(input ssr_addr_t a, input ssr_byte_t exp);
    ssr_byte_t d;
    u_ssr_host.do_rd(a, d);
    chk_byte(d, exp);
  endtask

  task pulse(input ssr_byte_t v);
    @(posedge MCLK);
    ev <= v;
    @(posedge MCLK);
    ev <= 8'h00;
    #1;
    st = upd(st, v, msk);
  endtask

  task wait_srq;
    int n;
    n = 0;
    while (srq !== 1'b1 && n < 8)
    begin
      @(posedge MCLK);
      #1;
      n++;
    end
    chk_bit(srq, 1'b1);
    if (srq !== 1'b1)
      final_report();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    e = ssr_byte_t'($urandom(32'hec6b350f));
    repeat (8) @(posedge MCLK);
    RESETN <= 1'b1;
    st = STATUS_RST;
    msk = MASK_RST;
    rdreg(OFF_QUERY, st);
    rdreg(OFF_MASK, 8'h00);
    chk_bit(srq, 1'b0);
    rdreg(4'h9, 8'h00);
    $display("test reset done");
    pulse(8'h80);
    rdreg(OFF_QUERY, st);
    rdreg(OFF_QUERY, st);
    pulse(8'h10);
    rdreg(OFF_QUERY, st & ~QUERY_HIDE);
    rdreg(OFF_POLL, st);
    rdreg(OFF_POLL, st);
    $display("test query done");
    u_ssr_host.do_wr(OFF_IRQ_EN, 8'h01);
    u_ssr_host.do_wr(OFF_MASK, 8'h2a);
    msk = 8'h2a;
    st = upd(st, 8'h00, msk);
    wait_srq();
    rdreg(OFF_MASK, 8'h2a);
    chk_bit(irq, 1'b1);
    rdreg(OFF_POLL, st);
    st = 8'h00;
    rdreg(OFF_QUERY, st);
    chk_bit(srq, 1'b0);
    rdreg(OFF_IRQ_STAT, 8'h03);
    u_ssr_host.do_wr(OFF_IRQ_CLR, 8'h07);
    rdreg(OFF_IRQ_STAT, 8'h00);
    u_ssr_host.do_wr(OFF_IRQ_EN, 8'h02);
    rdreg(OFF_IRQ_EN, 8'h02);
    @(posedge MCLK);
    #1;
    chk_bit(irq, 1'b0);
    $display("test request done");
    pulse(8'h01);
    chk_bit(srq, 1'b0);
    rdreg(OFF_QUERY, st);
    pulse(8'h02);
    chk_bit(srq, 1'b1);
    chk_bit(irq, 1'b0);
    rdreg(OFF_POLL, st);
    st = 8'h00;
    chk_bit(irq, 1'b1);
    @(posedge MCLK);
    ev <= 8'h20;
    u_ssr_host.do_wr(OFF_CLEAR, 8'h00);
    @(posedge MCLK);
    ev <= 8'h00;
    st = 8'h60;
    rdreg(OFF_QUERY, st);
    chk_bit(srq, 1'b1);
    u_ssr_host.do_wr(OFF_CLEAR, 8'h00);
    st = 8'h00;
    rdreg(OFF_QUERY, st);
    chk_bit(srq, 1'b0);
    $display("test clear done");
    u_ssr_host.gap = 2;
    repeat (20)
    begin
      msk = ssr_byte_t'($urandom);
      e = ssr_byte_t'($urandom) & 8'hbf;
      u_ssr_host.do_wr(OFF_MASK, msk);
      st = upd(st, 8'h00, msk);
      pulse(e);
      rdreg(OFF_QUERY, st & ~QUERY_HIDE);
      chk_bit(srq, st[BIT_SUMMARY]);
      u_ssr_host.do_wr(OFF_CLEAR, 8'h00);
      st = 8'h00;
    end
    $display("test random done");
    final_report();
  end
endmodule
